// >>> run_gate_defs.svh
// Offsets, field positions, reset values and timing counts for run and gate control
`ifndef RUN_GATE_DEFS_SVH
`define RUN_GATE_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_STATUS      8'h08
`define OFS_LEVEL_SET   8'h0c
`define OFS_LEVEL       8'h10
`define OFS_IP_STAGED   8'h14
`define OFS_PORT_STAGED 8'h18
`define OFS_IP_ACTIVE   8'h1c
`define OFS_PORT_ACTIVE 8'h20
`define OFS_DL_REQ      8'h24
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_INV_START  0
`define CTRL_INV_STOP   1
`define CTRL_INV_GATE   2
`define CTRL_INV_RUN    3
`define CTRL_START_USED 4
`define CTRL_GATE_ACQ   5
`define CTRL_EDGE_ACQ   6
`define CTRL_STRETCH    7
`define CTRL_ALL_REPLY  8
`define CTRL_W          9
`define CTRL_RESET      9'h010
// ----------------------------------------------------------------
// Command fields (write one to act)
// ----------------------------------------------------------------
`define CMD_START       0
`define CMD_STOP        1
`define CMD_RESTART     2
`define CMD_DL_RELEASE  3
// ----------------------------------------------------------------
// Level command fields and network defaults
// ----------------------------------------------------------------
`define LVL_ALL         8
`define LVL_CH_LO       2
`define LVL_CH_HI       7
`define IP_DEFAULT      32'hc0a8017b
`define PORT_DEFAULT    16'h1e61
`define USB_SRC         4'h8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ         250
`define STRETCH_NS      10000
`define STRETCH_CYC     ((`STRETCH_NS * `CLK_MHZ + 999) / 1000)
`define FRONT_HOLD_MS   1000
`define FRONT_HOLD_CYC  (`FRONT_HOLD_MS * 1000 * `CLK_MHZ)
`define RECORDS_8CH     56000
`define RECORDS_64CH    8000
`endif

// >>> run_gate_pkg.sv
// Types shared by the run and gate control block
package run_gate_pkg;
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} run_state_e;  // Run state
  typedef enum logic [1:0] {
    LVL_TTL_HIZ  = 2'b00,  // High-impedance TTL
    LVL_TTL_TERM = 2'b01,  // Terminated TTL
    LVL_NIM      = 2'b10   // NIM
  } level_e;
  typedef logic [3:0] src_t;  // Command source: 0..7 LAN, 8 USB
endpackage

// >>> counter_run_gate_control.sv
// Run, gate, snapshot, command framing and network staging for the counter unit
// Overview of operation
// - Start edge begins run, indicator lit
// - Stop edge ends the run
// - Host start command when start unused
// - Gate low suspends counting and indicator
// - Open gate input reads as high
// - Gate-acquisition mode stores record per gate-off
// - Edge acquisition keeps counting while gate low
// - Run output high while run and gate
// - Optional run pulse stretch to 10 us
// - ASCII messages end with CR LF
// - All-reply mode answers every command
// - Level commands set all or pair
// - Levels reset to high-impedance TTL
// - Level query returns eight channel levels
// - Network defaults address and port 7777
// - Address stored and returned as four octets
// - Port number stored and returned
// - Network change applied on restart only
// - Most recent command source wins
// - One download owner among eight connections
// - Download mutes replies, stop still accepted
// - Start and stop act on rising edge
// - Polarity of start, stop, gate, run invertible
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "run_gate_defs.svh"
module counter_run_gate_control #(
  parameter int CHANNELS       = 8,                 // Counting channels
  parameter int RECORDS        = `RECORDS_8CH,      // Snapshot capacity
  parameter int FRONT_HOLD_CYC = `FRONT_HOLD_CYC    // Front switch hold time
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  start_i,
  input  wire logic                  stop_i,
  input  wire logic                  gate_i,
  input  wire logic                  front_sw_i,
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_data_i,
  input  wire run_gate_pkg::src_t    rx_src_i,
  output logic                       run_o,
  output logic                       led_o,
  output logic                       snap_o,
  output logic      [31:0]           snap_addr_o,
  output logic                       line_done_o,
  output run_gate_pkg::src_t         line_src_o,
  output logic                       token_o,
  output logic                       token_nack_o,
  output logic                       reply_en_o,
  output logic      [2*CHANNELS-1:0] level_o,
  output logic      [31:0]           ip_o,
  output logic      [15:0]           port_o,
  output logic                       net_restart_o
);
  import run_gate_pkg::*;

  // ----------------------------------------------------------------
  // Register merge with byte lanes
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b]) res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]              sync1;          // First stage: start, stop, gate
  logic [2:0]              sync2;          // Second stage
  logic [2:0]              edge_prev;      // Previous active start, stop, gate
  logic [1:0]              sw_sync;        // Front switch synchroniser
  logic [31:0]             sw_cnt;         // Front switch hold counter
  logic                    sw_fired;       // Restart already issued this press
  logic [`CTRL_W-1:0]      ctrl;           // Control register
  run_state_e              state;          // Run state
  logic                    count_en_q;     // Previous counting valid
  logic [11:0]             stretch_cnt;    // Cycles since counting became valid
  logic [31:0]             rec_cnt;        // Stored records
  logic [1:0]              lvl [CHANNELS]; // Per-channel input level
  logic [31:0]             ip_staged;      // Staged address
  logic [15:0]             port_staged;    // Staged port
  logic                    seen_cr;        // Last byte was CR
  logic                    dl_busy;        // A download is owned
  src_t                    dl_owner;       // Owning connection
  logic                    dl_refused;     // Last request refused (held until the next request)

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire       wb_req     = wb_cyc_i & wb_stb_i;
  wire       wr         = wb_req & wb_we_i & wb_ack_o;           // Write lands with ack
  wire       wr_ctrl    = wr & (wb_adr_i == `OFS_CTRL);
  wire       wr_cmd     = wr & (wb_adr_i == `OFS_CMD) & wb_sel_i[0];
  wire       wr_lvl     = wr & (wb_adr_i == `OFS_LEVEL_SET) & (&wb_sel_i[1:0]);
  wire       wr_ip      = wr & (wb_adr_i == `OFS_IP_STAGED);
  wire       wr_port    = wr & (wb_adr_i == `OFS_PORT_STAGED);
  wire       wr_dl      = wr & (wb_adr_i == `OFS_DL_REQ) & wb_sel_i[0];
  wire       cmd_start  = wr_cmd & wb_dat_i[`CMD_START];
  wire       cmd_stop   = wr_cmd & wb_dat_i[`CMD_STOP];
  wire       cmd_rst    = wr_cmd & wb_dat_i[`CMD_RESTART];
  wire       cmd_rel    = wr_cmd & wb_dat_i[`CMD_DL_RELEASE];
  wire [2:0] pin_act    = sync2 ^ ctrl[`CTRL_INV_GATE:`CTRL_INV_START];
  wire       start_edge = pin_act[0] & ~edge_prev[0];
  wire       stop_edge  = pin_act[1] & ~edge_prev[1];
  wire       gate_act   = pin_act[2];   // Pin has a pull-up, open reads high
  wire       do_start   = ctrl[`CTRL_START_USED] ? start_edge : cmd_start;
  wire       do_stop    = stop_edge | cmd_stop;
  wire       running    = (state == ST_RUN);
  wire       count_en   = running & (gate_act | ctrl[`CTRL_EDGE_ACQ]);
  wire       run_act    = count_en | (ctrl[`CTRL_STRETCH] & ~count_en & stretch_cnt != 0
                          & stretch_cnt < 12'(`STRETCH_CYC));
  wire       gate_fall  = running & ctrl[`CTRL_GATE_ACQ] & edge_prev[2] & ~gate_act;
  wire       rec_full   = (rec_cnt >= 32'(RECORDS));
  wire       is_cr      = rx_valid_i & (rx_data_i == 8'h0d);
  wire       is_lf      = rx_valid_i & (rx_data_i == 8'h0a);
  wire       sw_hold    = sw_cnt >= 32'(FRONT_HOLD_CYC);
  wire       restart    = cmd_rst | (sw_hold & ~sw_fired);
  wire [5:0] lvl_ch     = wb_dat_i[`LVL_CH_HI:`LVL_CH_LO];
  wire [31:0] ctrl_merged = merge(32'(ctrl), wb_dat_i, wb_sel_i);                // Control after lanes
  wire [31:0] port_merged = merge({16'h0000, port_staged}, wb_dat_i, wb_sel_i); // Port after lanes

  // Status word assembled from live state
  wire [31:0] status_w = {rec_cnt[15:0], 3'h0, dl_refused, dl_owner, dl_busy, line_src_o,
                          gate_act, count_en, running};
  // Packed levels, two bits per channel, channel 0 lowest
  logic [2*CHANNELS-1:0] lvl_pack;
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
      lvl_pack[2*c +: 2] = lvl[c];
  end

  // Read multiplexer, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    case (wb_adr_i)
      `OFS_CTRL:        rd_mux = {{(32-`CTRL_W){1'b0}}, ctrl};
      `OFS_STATUS:      rd_mux = status_w;
      `OFS_LEVEL:       rd_mux = 32'(lvl_pack);
      `OFS_IP_STAGED:   rd_mux = ip_staged;
      `OFS_PORT_STAGED: rd_mux = {16'h0000, port_staged};
      `OFS_IP_ACTIVE:   rd_mux = ip_o;
      `OFS_PORT_ACTIVE: rd_mux = {16'h0000, port_o};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Wishbone slave: one wait state, ack one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // Control register with byte lanes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= `CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= ctrl_merged[`CTRL_W-1:0];
  end

  // ----------------------------------------------------------------
  // Input synchronisers and edge memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1     <= 3'h4;
      sync2     <= 3'h4;
      edge_prev <= 3'h7;   // No false edge right after reset
      sw_sync   <= 2'h0;
    end
    else
    begin
      sync1     <= {gate_i, stop_i, start_i};
      sync2     <= sync1;
      edge_prev <= pin_act;
      sw_sync   <= {sw_sync[0], front_sw_i};
    end
  end

  // ----------------------------------------------------------------
  // Run state: stop wins over a simultaneous start
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE: if (do_start && !do_stop) state <= ST_RUN;
        ST_RUN:  if (do_stop) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Run output, indicator and stretch counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_en_q  <= 1'b0;
      stretch_cnt <= 12'h000;
      run_o       <= 1'b0;
      led_o       <= 1'b0;
    end
    else
    begin
      count_en_q <= count_en;
      if (count_en && !count_en_q)
        stretch_cnt <= 12'h001;
      else if (stretch_cnt != 12'h000 && stretch_cnt < 12'(`STRETCH_CYC))
        stretch_cnt <= stretch_cnt + 12'h001;
      run_o <= run_act ^ ctrl[`CTRL_INV_RUN];
      led_o <= count_en;
    end
  end

  // ----------------------------------------------------------------
  // Gate-off snapshots
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      snap_o      <= 1'b0;
      snap_addr_o <= 32'h0000_0000;
      rec_cnt     <= 32'h0000_0000;
    end
    else
    begin
      snap_o <= gate_fall & ~rec_full;
      if (do_start && state == ST_IDLE)
        rec_cnt <= 32'h0000_0000;                                    // New run, new records
      else if (gate_fall && !rec_full)
      begin
        snap_addr_o <= rec_cnt;
        rec_cnt     <= rec_cnt + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input levels, per channel pair or all
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < CHANNELS; c++)
        lvl[c] <= LVL_TTL_HIZ;
    end
    else if (wr_lvl && wb_dat_i[1:0] != 2'h3)
    begin
      for (int c = 0; c < CHANNELS; c++)
        if (wb_dat_i[`LVL_ALL] || c == int'(lvl_ch) || c == int'(lvl_ch) + 1)
          lvl[c] <= wb_dat_i[1:0];
    end
  end
  assign level_o = lvl_pack;

  // ----------------------------------------------------------------
  // Network staging and restart
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ip_staged     <= `IP_DEFAULT;
      port_staged   <= `PORT_DEFAULT;
      ip_o          <= `IP_DEFAULT;
      port_o        <= `PORT_DEFAULT;
      sw_cnt        <= 32'h0000_0000;
      sw_fired      <= 1'b0;
      net_restart_o <= 1'b0;
    end
    else
    begin
      if (wr_ip)
        ip_staged <= merge(ip_staged, wb_dat_i, wb_sel_i);
      if (wr_port)
        port_staged <= port_merged[15:0];
      sw_cnt   <= sw_sync[1] ? (sw_hold ? sw_cnt : sw_cnt + 32'h0000_0001) : 32'h0000_0000;
      sw_fired <= sw_sync[1] & (sw_fired | sw_hold);
      net_restart_o <= restart;
      if (restart)
      begin
        ip_o   <= ip_staged;
        port_o <= port_staged;
      end
    end
  end

  // ----------------------------------------------------------------
  // Message framing, source tracking, reply tokens, download lock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seen_cr      <= 1'b0;
      line_done_o  <= 1'b0;
      line_src_o   <= `USB_SRC;
      token_o      <= 1'b0;
      token_nack_o <= 1'b0;
      dl_busy      <= 1'b0;
      dl_owner     <= 4'h0;
      dl_refused   <= 1'b0;
    end
    else
    begin
      if (rx_valid_i)
        seen_cr <= is_cr;
      line_done_o  <= is_lf & seen_cr;
      if (is_lf)
        line_src_o <= rx_src_i;
      token_o      <= is_lf & ctrl[`CTRL_ALL_REPLY] & ~dl_busy;
      token_nack_o <= is_lf & ~seen_cr;                              // Bare LF is refused
      if (wr_dl && !dl_busy && wb_dat_i[3:0] < `USB_SRC)
      begin
        dl_busy  <= 1'b1;                         // Grant beats a same-cycle stop
        dl_owner <= wb_dat_i[3:0];
      end
      else if (cmd_rel || do_stop)
        dl_busy <= 1'b0;
      if (wr_dl)
        dl_refused <= dl_busy;
    end
  end
  assign reply_en_o = ~dl_busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  run_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ST_IDLE && do_start && !do_stop) |=> running)
    else $error("run did not start on start event");
  run_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_edge |=> !running)
    else $error("run did not end on stop edge");
  gate_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (running && !gate_act && !ctrl[`CTRL_EDGE_ACQ]) |=> !led_o)
    else $error("indicator lit while gate low");
  edge_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (running && ctrl[`CTRL_EDGE_ACQ]) |=> led_o)
    else $error("edge mode stopped counting");
  run_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count_en |=> (run_o != $past(ctrl[`CTRL_INV_RUN])))
    else $error("run output not active while counting");
  stretch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[`CTRL_STRETCH] && !ctrl[`CTRL_INV_RUN] && $fell(count_en)
     && stretch_cnt < 12'(`STRETCH_CYC)) |=> run_o)
    else $error("short run pulse not stretched");
  snap_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (gate_fall && !rec_full) |=> snap_o ##1 !snap_o)
    else $error("gate-off snapshot missing");
  net_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!restart && !$past(restart)) |-> $stable(ip_o))
    else $error("network address changed without restart");
  dl_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dl_busy && !cmd_rel && !do_stop) |=> (dl_busy && $stable(dl_owner)))
    else $error("download owner changed while busy");
  reply_mute_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dl_busy |=> !token_o)
    else $error("reply token during download");
endmodule // counter_run_gate_control

// >>> host_link_model.sv
// Host computer model feeding framed command bytes into the link port
`timescale 1ns/10ps
module host_link_model
(
  input  wire logic       clk_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic      [3:0] rx_src_o
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5a;
    rx_src_o   = 4'h0;
  end

  // ----------------------------------------------------------------
  // One ASCII line, one byte a cycle, closed by CR LF
  // ----------------------------------------------------------------
  task automatic send_line(input logic [3:0] src, input string s);
    string t;
    begin
      t = {s, "\r\n"};
      for (int i = 0; i < t.len(); i++)
      begin
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_src_o   <= src;
        rx_data_o  <= t[i];
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~rx_data_o;  // Released data never holds the last byte
      rx_src_o   <= ~src;
    end
  endtask
endmodule // host_link_model

// >>> counter_run_gate_control_tb.sv
// Self-checking bench for run and gate control
`timescale 1ns/10ps
`include "run_gate_defs.svh"
module counter_run_gate_control_tb;
  import run_gate_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, start_i = 1'b0, stop_i = 1'b0;
  logic gate_i = 1'b1, front_sw_i = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, wb_dat_o, ip_o, rd, exp_ip, r;
  logic [15:0] level_o, port_o, exp_port;
  logic wb_ack_o, run_o, led_o, snap_o, line_done_o, token_o, token_nack_o, reply_en_o;
  logic net_restart_o, rx_valid_i;
  logic [7:0] rx_data_i;
  src_t rx_src_i, line_src_o;
  int fail_count = 0, n_checks = 0, snaps = 0, lines = 0, cycles = 0, ch, seed = 32'h46d35a75;
  int exp_lvl[8];
  int toks = 0, nacks = 0, rsts = 0;
  logic [31:0] snap_addr_o;

  always #2 clk_i = ~clk_i;  // 250 MHz

  counter_run_gate_control #(.FRONT_HOLD_CYC(20), .RECORDS(4)) u_counter_run_gate_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .start_i(start_i), .stop_i(stop_i), .gate_i(gate_i), .front_sw_i(front_sw_i),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_src_i(rx_src_i), .run_o(run_o),
    .led_o(led_o), .snap_o(snap_o), .snap_addr_o(snap_addr_o), .line_done_o(line_done_o),
    .line_src_o(line_src_o), .token_o(token_o), .token_nack_o(token_nack_o),
    .reply_en_o(reply_en_o), .level_o(level_o), .ip_o(ip_o), .port_o(port_o),
    .net_restart_o(net_restart_o));

  host_link_model u_host_link_model (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_src_o(rx_src_i));

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    snaps  = snaps + (snap_o === 1'b1);
    lines  = lines + (line_done_o === 1'b1);
    toks   = toks + (token_o === 1'b1);
    nacks  = nacks + (token_nack_o === 1'b1);
    rsts   = rsts + (net_restart_o === 1'b1);
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);  // Held until ack seen
    rd = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pulse(input logic stop);
    @(posedge clk_i);
    if (stop)
      stop_i <= 1'b1;
    else
      start_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    if (stop)
      stop_i <= 1'b0;
    else
      start_i <= 1'b0;
  endtask

  task automatic wait_run(input logic v);
    for (int n = 0; n < 40 && run_o !== v; n++) @(posedge clk_i);
  endtask

  // Run with gate dropped under one control setting
  task automatic gate_case(input logic [31:0] ctl, input logic exp_run, input int exp_snap);
    wb(1'b1, `OFS_CTRL, ctl);
    snaps = 0;
    pulse(1'b0);
    wait_run(1'b1);
    chk("run after start", 1, run_o);
    chk("led after start", 1, led_o);
    gate_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("run gate low", exp_run, run_o);
    chk("led gate low", exp_run, led_o);
    chk("records", exp_snap, snaps);
    chk("record index", 0, snap_addr_o);
    gate_i <= 1'b1;
    wait_run(1'b1);
    chk("run gate back", 1, run_o);
    pulse(1'b1);
    wait_run(1'b0);
    chk("run after stop", 0, run_o);
    wb(1'b0, `OFS_STATUS, 0);
    chk("record count", exp_snap, rd[31:16]);
    $display("test gate case %h done", ctl);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    exp_ip   = 32'hc0a8017b;
    exp_port = 16'd7777;
    foreach (exp_lvl[i]) exp_lvl[i] = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("ip default", exp_ip, ip_o);
    chk("port default", exp_port, port_o);
    chk("levels default", 0, level_o);
    wb(1'b0, `OFS_CTRL, 0);
    chk("ctrl reset", 32'h010, rd);
    wb(1'b0, 8'h3c, 0);
    chk("unmapped read", 0, rd);
    $display("test reset done");
    gate_case(32'h010, 1'b0, 0);
    gate_case(32'h030, 1'b0, 1);
    gate_case(32'h050, 1'b1, 0);
    // Short count with the run output stretched
    wb(1'b1, `OFS_CTRL, 32'h090);
    pulse(1'b0);
    wait_run(1'b1);
    gate_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("run stretched", 1, run_o);
    chk("led short count", 0, led_o);
    repeat (2600) @(posedge clk_i);
    chk("stretch over", 0, run_o);
    gate_i <= 1'b1;
    pulse(1'b1);
    $display("test stretch done");
    // Host start with start pin unused
    wb(1'b1, `OFS_CTRL, 32'h000);
    wb(1'b1, `OFS_CMD, 32'h1);
    wait_run(1'b1);
    chk("command start", 1, run_o);
    wb(1'b1, `OFS_CMD, 32'h2);
    wait_run(1'b0);
    chk("command stop", 0, run_o);
    wb(1'b1, `OFS_CTRL, 32'h018);
    repeat (4) @(posedge clk_i);
    chk("run inverted idle", 1, run_o);
    wb(1'b1, `OFS_CTRL, 32'h010);
    $display("test commands done");
    // Level settings, all then pairs, every code
    for (int c = 0; c < 3; c++)
    begin
      ch = $unsigned($random(seed)) % 7;
      wb(1'b1, `OFS_LEVEL_SET, 32'h100 | (2 - c));
      foreach (exp_lvl[i]) exp_lvl[i] = 2 - c;
      wb(1'b1, `OFS_LEVEL_SET, (ch << 2) | c);
      exp_lvl[ch] = c;
      exp_lvl[ch + 1] = c;
      wb(1'b1, `OFS_LEVEL_SET, 32'h103);  // Code 11 is ignored
      r = 0;
      foreach (exp_lvl[i]) r[2*i +: 2] = exp_lvl[i];
      @(posedge clk_i);
      chk("levels", r, level_o);
      wb(1'b0, `OFS_LEVEL, 0);
      chk("level read", r, rd);
    end
    $display("test levels done");
    // Staged network settings, applied by restart and by switch
    for (int k = 0; k < 2; k++)
    begin
      r = $random(seed);
      wb(1'b1, `OFS_IP_STAGED, r);
      wb(1'b1, `OFS_PORT_STAGED, r[31:16]);
      chk("ip held", exp_ip, ip_o);
      chk("port held", exp_port, port_o);
      wb(1'b0, `OFS_IP_STAGED, 0);
      chk("ip staged", r, rd);
      wb(1'b0, `OFS_PORT_STAGED, 0);
      chk("port staged", r[31:16], rd);
      if (k == 0)
        wb(1'b1, `OFS_CMD, 32'h4);
      else
        front_sw_i <= 1'b1;
      repeat (30) @(posedge clk_i);
      front_sw_i <= 1'b0;
      exp_ip   = r;
      exp_port = r[31:16];
      chk("ip applied", exp_ip, ip_o);
      chk("port applied", exp_port, port_o);
    end
    chk("restart pulses", 2, rsts);
    $display("test network done");
    // Framed lines from two sources
    lines = 0;
    u_host_link_model.send_line(4'h3, "AB");
    repeat (3) @(posedge clk_i);
    chk("lines", 1, lines);
    chk("line source", 4'h3, line_src_o);
    u_host_link_model.send_line(4'h8, "C");
    repeat (3) @(posedge clk_i);
    chk("line source usb", 4'h8, line_src_o);
    chk("no token unasked", 0, toks);
    // All-reply mode: bare LF refused, every line answered
    wb(1'b1, `OFS_CTRL, 32'h110);
    lines = 0;
    u_host_link_model.send_line(4'h1, "\n");
    repeat (3) @(posedge clk_i);
    chk("tokens", 2, toks);
    chk("negative tokens", 1, nacks);
    chk("lines all reply", 1, lines);
    // One download owner, replies muted until release
    wb(1'b1, `OFS_DL_REQ, 32'h5);
    chk("replies muted", 0, reply_en_o);
    wb(1'b1, `OFS_DL_REQ, 32'h2);
    wb(1'b0, `OFS_STATUS, 0);
    chk("download owner", 32'h1580, rd & 32'h0000_1f80);
    u_host_link_model.send_line(4'h2, "D");
    repeat (3) @(posedge clk_i);
    chk("token muted", 2, toks);
    wb(1'b1, `OFS_CMD, 32'h8);
    chk("replies back", 1, reply_en_o);
    $display("test framing done");
    final_report();
  end
endmodule // counter_run_gate_control_tb
